// *** logic/setpoint_regs.vh ***
// Purpose: register map, field positions and reset values of the setpoint programmer
// Assumes: 32-bit AXI4-Lite slave, byte addresses
// Notes: definitions only
`ifndef SETPOINT_REGS_VH
`define SETPOINT_REGS_VH

// register byte offsets
`define SP_OFF_CTRL 8'h00
`define SP_OFF_REPEAT 8'h04
`define SP_OFF_CYCLE 8'h08
`define SP_OFF_NROWS 8'h0C
`define SP_OFF_STATUS 8'h10
`define SP_OFF_SETPOINT 8'h14
`define SP_OFF_TABLE_LO 8'h40
`define SP_OFF_TABLE_HI 8'hBC

// control register fields
`define SP_CTRL_TABSRC 0
`define SP_CTRL_INFINITE 1
`define SP_CTRL_START_EDGE 4
`define SP_CTRL_START_INV 5
`define SP_CTRL_PAUSE_EDGE 6
`define SP_CTRL_PAUSE_INV 7
`define SP_CTRL_RESET_EDGE 8
`define SP_CTRL_RESET_INV 9
`define SP_CTRL_MASK 32'h000003F3

// table entry fields
`define SP_TIME_TRIG 31
`define SP_TIME_MASK 32'h8000FFFF

// status fields
`define SP_ST_RUN 0
`define SP_ST_PAUSE 1
`define SP_ST_DONE 2
`define SP_ST_IDX_LO 8
`define SP_ST_REP_LO 16

// reset values and limits
`define SP_RST_CTRL 32'h00000010
`define SP_RST_REPEAT 16'h0001
`define SP_RST_CYCLE 32'h000000FA
`define SP_RST_NROWS 5'h02
`define SP_MIN_CYCLE 32'h00000020
`define SP_MIN_ROWS 5'h02
`define SP_MAX_ROWS 5'h10
`define SP_DIV_STEPS 5'h11

// bus responses
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// *** logic/cond_detect.v ***
// Purpose: samples one condition input per cycle tick, level or edge qualified
// Assumes: din synchronous to clk; tick is a one-cycle pulse
// Notes: in edge mode act is a one-cycle pulse, in level mode it follows the sample
`timescale 1ns/1ps
module cond_detect (
	input wire clk, // processing clock
	input wire rst_n, // asynchronous reset, active low
	input wire tick, // cycle tick pulse
	input wire din, // raw condition input
	input wire edge_mode, // 1 edge, 0 level
	input wire invert, // 1 falling edge or low level active
	output reg act_r // qualified condition
);
	reg prev_r;
	reg primed_r;
	wire smp;

	assign smp = din ^ invert;

	// sample on tick, compare with previous sample for edges;
	// the first tick after reset only primes the history, so an
	// inverted idle line does not look like an edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			primed_r <= 1'b0;
			act_r <= 1'b0;
		end else if (tick) begin
			prev_r <= smp;
			primed_r <= 1'b1;
			act_r <= edge_mode ? (smp & ~prev_r & primed_r) : smp;
		end else if (edge_mode) begin
			act_r <= 1'b0;
		end
	end
endmodule

// *** logic/setpoint_programmer.v ***
// Purpose: setpoint programmer stepping a time/value table with linear ramps
// Assumes: AXI4-Lite register access; condition inputs synchronous to CLK
// Notes: global table read combinationally on GTAB_* in the same cycle as GTAB_IDX
`timescale 1ns/1ps
`include "setpoint_regs.vh"
module setpoint_programmer (
	input wire CLK, // 250 MHz processing clock
	input wire RESET_N, // asynchronous reset, active low
	input wire [7:0] S_AXI_AWADDR, // write address
	input wire S_AXI_AWVALID, // write address valid
	output reg S_AXI_AWREADY, // write address ready
	input wire [31:0] S_AXI_WDATA, // write data
	input wire [3:0] S_AXI_WSTRB, // write byte enables
	input wire S_AXI_WVALID, // write data valid
	output reg S_AXI_WREADY, // write data ready
	output reg [1:0] S_AXI_BRESP, // write response
	output reg S_AXI_BVALID, // write response valid
	input wire S_AXI_BREADY, // write response ready
	input wire [7:0] S_AXI_ARADDR, // read address
	input wire S_AXI_ARVALID, // read address valid
	output reg S_AXI_ARREADY, // read address ready
	output reg [31:0] S_AXI_RDATA, // read data
	output reg [1:0] S_AXI_RRESP, // read response
	output reg S_AXI_RVALID, // read data valid
	input wire S_AXI_RREADY, // read data ready
	input wire START_IN, // start condition
	input wire PAUSE_IN, // pause condition
	input wire RESET_IN, // program reset condition
	input wire TRIG_IN, // step trigger, rising edge
	output reg [3:0] GTAB_IDX, // global table row index
	input wire [31:0] GTAB_TIME, // global row time word
	input wire [15:0] GTAB_VALUE, // global row value
	input wire [4:0] GTAB_ROWS, // global table row count
	output reg [15:0] SETPOINT, // setpoint output, signed
	output reg RUNNING, // program executing
	output reg PAUSED, // pause in effect
	output reg DONE // all repetitions finished
);
	localparam ST_IDLE = 3'h0;
	localparam ST_FETCH = 3'h1;
	localparam ST_DIV = 3'h2;
	localparam ST_RAMP = 3'h3;
	localparam ST_DONE = 3'h4;

	// configuration and table storage
	reg [31:0] ctrl_r;
	reg [15:0] repeat_r;
	reg [31:0] cycle_r;
	reg [4:0] nrows_r;
	reg [31:0] ltime_r [0:15];
	reg [15:0] lval_r [0:15];

	// bus slave state
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_got_r;
	reg w_got_r;

	// sequencer state
	reg [2:0] state_r;
	reg [3:0] idx_r;
	reg run_r;
	reg [15:0] rep_left_r;
	reg pause_latch_r;
	reg signed [15:0] sp_r;
	reg signed [15:0] target_r;
	reg [15:0] dur_r;
	reg [15:0] elapsed_r;
	reg trig_step_r;
	reg neg_r;
	reg [16:0] quo_r;
	reg [16:0] rem_r;
	reg [15:0] err_r;
	reg [4:0] div_cnt_r;
	reg [31:0] tick_cnt_r;
	reg tick_r;

	wire [3:0] cond_in;
	wire [3:0] cond_edge;
	wire [3:0] cond_inv;
	wire [3:0] cond_act;
	wire start_act;
	wire pause_act;
	wire reset_act;
	wire trig_act;
	wire paused;
	wire [31:0] row_time;
	wire signed [15:0] row_val;
	wire [4:0] rows_raw;
	wire [3:0] last_idx;
	wire [15:0] rep_cfg;
	wire [31:0] cycle_eff;
	wire signed [16:0] delta;
	wire [16:0] mag;
	wire [16:0] div_try;
	wire [16:0] err_sum;
	wire [16:0] inc;
	wire [31:0] wmask;
	wire wr_fire;
	wire [5:0] wr_word;
	wire [5:0] rd_word;
	wire wr_tab;
	wire rd_tab;
	wire row_ok;
	wire [7:0] wr_rel;
	wire [7:0] rd_rel;
	reg [31:0] rd_val;
	reg rd_ok;

	// condition channels: start, pause, reset, trigger
	assign cond_in = {TRIG_IN, RESET_IN, PAUSE_IN, START_IN};
	assign cond_edge = {1'b1, ctrl_r[`SP_CTRL_RESET_EDGE], ctrl_r[`SP_CTRL_PAUSE_EDGE],
		ctrl_r[`SP_CTRL_START_EDGE]};
	assign cond_inv = {1'b0, ctrl_r[`SP_CTRL_RESET_INV], ctrl_r[`SP_CTRL_PAUSE_INV],
		ctrl_r[`SP_CTRL_START_INV]};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cond
			cond_detect u_cond (
				.clk(CLK),
				.rst_n(RESET_N),
				.tick(tick_r),
				.din(cond_in[gi]),
				.edge_mode(cond_edge[gi]),
				.invert(cond_inv[gi]),
				.act_r(cond_act[gi])
			);
		end
	endgenerate

	assign start_act = cond_act[0];
	assign pause_act = cond_act[1];
	assign reset_act = cond_act[2];
	assign trig_act = cond_act[3];
	// edge pause latches between edges, level pause follows input;
	// a reset event cancels it, though a held level pause returns after
	assign paused = !reset_act &&
		(ctrl_r[`SP_CTRL_PAUSE_EDGE] ? pause_latch_r : pause_act);

	// row source select
	assign row_time = ctrl_r[`SP_CTRL_TABSRC] ? GTAB_TIME : ltime_r[idx_r];
	assign row_val = ctrl_r[`SP_CTRL_TABSRC] ? GTAB_VALUE : lval_r[idx_r];
	assign rows_raw = ctrl_r[`SP_CTRL_TABSRC] ? GTAB_ROWS : nrows_r;
	// global rows answer GTAB_IDX, which trails idx_r by one clock
	assign row_ok = !ctrl_r[`SP_CTRL_TABSRC] || (GTAB_IDX == idx_r);
	// fewer than two rows cannot form a ramp, so clamp
	assign last_idx = (rows_raw < `SP_MIN_ROWS) ? 4'h1 :
		(rows_raw > `SP_MAX_ROWS) ? 4'hF : rows_raw[3:0] - 4'h1;
	assign rep_cfg = (repeat_r == 16'h0000) ? 16'h0001 : repeat_r;
	// divider needs up to 18 cycles per step, so ticks are kept longer
	assign cycle_eff = (cycle_r < `SP_MIN_CYCLE) ? `SP_MIN_CYCLE : cycle_r;

	// ramp arithmetic
	assign delta = {row_val[15], row_val} - {sp_r[15], sp_r};
	assign mag = delta[16] ? (17'h00000 - delta) : delta;
	assign div_try = {rem_r[15:0], quo_r[16]};
	assign err_sum = {1'b0, err_r} + rem_r;
	assign inc = quo_r + {16'h0000, (err_sum >= {1'b0, dur_r})};

	// cycle tick generator
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tick_cnt_r <= 32'h00000000;
			tick_r <= 1'b0;
		end else if (tick_cnt_r >= cycle_eff - 32'h00000001) begin
			tick_cnt_r <= 32'h00000000;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h00000001;
			tick_r <= 1'b0;
		end
	end

	// sequencer: reset over pause over start
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= ST_IDLE;
			idx_r <= 4'h0;
			run_r <= 1'b0;
			rep_left_r <= 16'h0000;
			pause_latch_r <= 1'b0;
			sp_r <= 16'h0000;
			target_r <= 16'h0000;
			dur_r <= 16'h0000;
			elapsed_r <= 16'h0000;
			trig_step_r <= 1'b0;
			neg_r <= 1'b0;
			quo_r <= 17'h00000;
			rem_r <= 17'h00000;
			err_r <= 16'h0000;
			div_cnt_r <= 5'h00;
		end else if (reset_act) begin
			state_r <= ST_FETCH;
			idx_r <= 4'h0;
			run_r <= 1'b0;
			pause_latch_r <= 1'b0;
			// a held reset level still shows the first step
			if (idx_r == 4'h0 && row_ok)
				sp_r <= row_val;
		end else begin
			if (pause_act && ctrl_r[`SP_CTRL_PAUSE_EDGE])
				pause_latch_r <= ~pause_latch_r;
			case (state_r)
				ST_IDLE, ST_DONE: begin
					// a held start level restarts after completion too
					// a pause edge in the same tick still wins over start
					if (start_act && !paused && !pause_act) begin
						state_r <= ST_FETCH;
						idx_r <= 4'h0;
						run_r <= 1'b1;
						rep_left_r <= rep_cfg;
					end
				end
				ST_FETCH: begin
					// wait for the global row to settle; a paused run stays put
					if (!row_ok || (run_r && paused)) begin
						state_r <= ST_FETCH;
					end else if (idx_r == 4'h0) begin
						sp_r <= row_val;
						if (run_r) begin
							idx_r <= 4'h1;
						end else begin
							state_r <= ST_IDLE;
						end
					end else begin
						target_r <= row_val;
						dur_r <= row_time[15:0];
						trig_step_r <= row_time[`SP_TIME_TRIG];
						neg_r <= delta[16];
						quo_r <= mag;
						rem_r <= 17'h00000;
						err_r <= 16'h0000;
						elapsed_r <= 16'h0000;
						div_cnt_r <= 5'h00;
						state_r <= ST_DIV;
					end
				end
				ST_DIV: begin
					// restoring division of ramp height by step ticks
					if (trig_step_r || dur_r == 16'h0000 || div_cnt_r == `SP_DIV_STEPS) begin
						state_r <= ST_RAMP;
					end else begin
						div_cnt_r <= div_cnt_r + 5'h01;
						if (div_try >= {1'b0, dur_r}) begin
							rem_r <= div_try - {1'b0, dur_r};
							quo_r <= {quo_r[15:0], 1'b1};
						end else begin
							rem_r <= div_try;
							quo_r <= {quo_r[15:0], 1'b0};
						end
					end
				end
				ST_RAMP: begin
					if (paused) begin
						state_r <= ST_RAMP;
					end else if ((trig_step_r && trig_act) || (!trig_step_r &&
						(dur_r == 16'h0000 || (tick_r && elapsed_r == dur_r - 16'h0001)))) begin
						sp_r <= target_r;
						if (idx_r != last_idx) begin
							idx_r <= idx_r + 4'h1;
							state_r <= ST_FETCH;
						end else if (ctrl_r[`SP_CTRL_INFINITE] || rep_left_r > 16'h0001) begin
							if (!ctrl_r[`SP_CTRL_INFINITE])
								rep_left_r <= rep_left_r - 16'h0001;
							idx_r <= 4'h0;
							state_r <= ST_FETCH;
						end else begin
							rep_left_r <= 16'h0000;
							run_r <= 1'b0;
							state_r <= ST_DONE;
						end
					end else if (!trig_step_r && tick_r) begin
						// remainder carried so the ramp lands exactly on time
						elapsed_r <= elapsed_r + 16'h0001;
						err_r <= (err_sum >= {1'b0, dur_r}) ? err_sum[15:0] - dur_r :
							err_sum[15:0];
						sp_r <= neg_r ? sp_r - inc[15:0] : sp_r + inc[15:0];
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// registered outputs
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SETPOINT <= 16'h0000;
			RUNNING <= 1'b0;
			PAUSED <= 1'b0;
			DONE <= 1'b0;
			GTAB_IDX <= 4'h0;
		end else begin
			SETPOINT <= sp_r;
			RUNNING <= run_r;
			PAUSED <= paused;
			DONE <= (state_r == ST_DONE);
			GTAB_IDX <= idx_r;
		end
	end

	// bus decode helpers
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wr_fire = aw_got_r && w_got_r && !S_AXI_BVALID;
	assign wr_tab = (awaddr_r >= `SP_OFF_TABLE_LO) && (awaddr_r <= `SP_OFF_TABLE_HI);
	assign rd_tab = (S_AXI_ARADDR >= `SP_OFF_TABLE_LO) && (S_AXI_ARADDR <= `SP_OFF_TABLE_HI);
	assign wr_rel = awaddr_r - `SP_OFF_TABLE_LO;
	assign rd_rel = S_AXI_ARADDR - `SP_OFF_TABLE_LO;
	assign wr_word = wr_rel[7:2];
	assign rd_word = rd_rel[7:2];

	// read mux; table words alternate time, value
	always @* begin
		rd_val = 32'h00000000;
		rd_ok = 1'b1;
		if (rd_tab) begin
			rd_val = rd_word[0] ? {16'h0000, lval_r[rd_word[4:1]]} : ltime_r[rd_word[4:1]];
		end else begin
			case (S_AXI_ARADDR)
				`SP_OFF_CTRL: rd_val = ctrl_r;
				`SP_OFF_REPEAT: rd_val = {16'h0000, repeat_r};
				`SP_OFF_CYCLE: rd_val = cycle_r;
				`SP_OFF_NROWS: rd_val = {27'h0000000, nrows_r};
				`SP_OFF_STATUS: rd_val = {rep_left_r, 4'h0, idx_r, 5'h00,
					(state_r == ST_DONE), paused, run_r};
				`SP_OFF_SETPOINT: rd_val = {{16{sp_r[15]}}, sp_r};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// write channel: address and data taken in either order
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `AXI_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			ctrl_r <= `SP_RST_CTRL;
			repeat_r <= `SP_RST_REPEAT;
			cycle_r <= `SP_RST_CYCLE;
			nrows_r <= `SP_RST_NROWS;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				awaddr_r <= {S_AXI_AWADDR[7:2], 2'h0};
				aw_got_r <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
				w_got_r <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `AXI_OKAY;
				case (awaddr_r)
					`SP_OFF_CTRL: ctrl_r <= ((ctrl_r & ~wmask) | (wdata_r & wmask)) &
						`SP_CTRL_MASK;
					`SP_OFF_REPEAT: repeat_r <= (repeat_r & ~wmask[15:0]) |
						(wdata_r[15:0] & wmask[15:0]);
					`SP_OFF_CYCLE: cycle_r <= (cycle_r & ~wmask) | (wdata_r & wmask);
					`SP_OFF_NROWS: nrows_r <= wstrb_r[0] ? wdata_r[4:0] : nrows_r;
					`SP_OFF_STATUS, `SP_OFF_SETPOINT: S_AXI_BRESP <= `AXI_OKAY;
					default: S_AXI_BRESP <= wr_tab ? `AXI_OKAY : `AXI_SLVERR;
				endcase
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// local table words, one generate entry per row
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_row
			always @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					ltime_r[gi] <= 32'h00000000;
					lval_r[gi] <= 16'h0000;
				end else if (wr_fire && wr_tab && wr_word[4:1] == gi) begin
					if (wr_word[0])
						lval_r[gi] <= (lval_r[gi] & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
					else
						ltime_r[gi] <= ((ltime_r[gi] & ~wmask) | (wdata_r & wmask)) &
							`SP_TIME_MASK;
				end
			end
		end
	endgenerate

	// read channel, answer one cycle after address taken
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `AXI_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_val;
			S_AXI_RRESP <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end
endmodule

// *** sim/setpoint_programmer_checker.sv ***
// Purpose: port timing checks of the setpoint programmer
// Assumes: bound onto the design top, one clock domain
// Notes: sequencer checks rely on ticks being at least 32 clocks apart
`timescale 1ns/1ps
module setpoint_programmer_checker (
	input wire CLK, // clock
	input wire RESET_N, // reset, active low
	input wire S_AXI_AWVALID, // aw valid
	input wire S_AXI_AWREADY, // aw ready
	input wire S_AXI_WVALID, // w valid
	input wire S_AXI_WREADY, // w ready
	input wire S_AXI_BVALID, // b valid
	input wire S_AXI_ARVALID, // ar valid
	input wire S_AXI_ARREADY, // ar ready
	input wire S_AXI_RVALID, // r valid
	input wire [15:0] SETPOINT, // setpoint
	input wire RUNNING, // running
	input wire PAUSED, // paused
	input wire DONE // done
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// write answer two clocks after both halves are taken, read answer one
	write_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer late");
	read_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("address taken during answer");
	ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken during answer");
	// finished program is idle and holds its last value
	done_idle_a: assert property (DONE |-> !RUNNING) else $error("done while running");
	done_hold_a: assert property (DONE && $past(DONE) |-> $stable(SETPOINT))
		else $error("setpoint moved after done");
	// a reset may move the idle output back to the first step during a pause
	pause_freeze_a: assert property (PAUSED && $past(PAUSED) && RUNNING |-> $stable(SETPOINT))
		else $error("setpoint moved in pause");
	start_pause_a: assert property ($rose(RUNNING) |-> !PAUSED)
		else $error("start during pause");
	// the only back-to-back pair is a landing followed by the jump to row 0;
	// fetch and divide keep any further move at least a clock away
	tick_pace_a: assert property ($changed(SETPOINT) ##1 $changed(SETPOINT) |=> $stable(SETPOINT))
		else $error("setpoint updated off tick");
endmodule

// *** sim/cond_partner.sv ***
// Purpose: condition lines and global table beside the programmer
// Assumes: bench calls drive just after a rising edge
// Notes: rows past the table give a changing pattern, never a stale row
`timescale 1ns/1ps
module cond_partner (
	input wire CLK, // clock
	input wire [3:0] GTAB_IDX, // row asked for
	output logic START_IN, // start line
	output logic PAUSE_IN, // pause line
	output logic RESET_IN, // reset line
	output logic TRIG_IN, // trigger line
	output logic [31:0] GTAB_TIME, // row time
	output logic [15:0] GTAB_VALUE, // row value
	output logic [4:0] GTAB_ROWS // row count
);
	logic [15:0] junk_r = 16'h5A5A;
	initial {TRIG_IN, RESET_IN, PAUSE_IN, START_IN} = 4'h0;
	// lines change only by nba so the design samples them cleanly
	task automatic drive(input logic [3:0] v);
		{TRIG_IN, RESET_IN, PAUSE_IN, START_IN} <= v;
	endtask
	always @(posedge CLK) begin
		junk_r <= ~junk_r + 16'h0001;
	end
	// start point, a two tick ramp, then a trigger step
	always_comb begin
		GTAB_ROWS = 5'h03;
		case (GTAB_IDX)
		4'h0: {GTAB_TIME, GTAB_VALUE} = {32'h00000000, 16'h0010};
		4'h1: {GTAB_TIME, GTAB_VALUE} = {32'h00000002, 16'h0020};
		4'h2: {GTAB_TIME, GTAB_VALUE} = {32'h80000000, 16'h0030};
		default: {GTAB_TIME, GTAB_VALUE} = {~junk_r, junk_r, junk_r};
		endcase
	end
endmodule

// *** sim/setpoint_programmer_tb.sv ***
// Purpose: self-checking bench for the setpoint programmer
// Assumes: cycle register at its floor, so one tick is 32 clocks
// Notes: every bus channel is held until its ready is sampled
`timescale 1ns/1ps
module setpoint_programmer_tb;
	localparam int TK = 32; // clocks per tick
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [3:0] cv = 4'h0;
	logic [31:0] d;
	logic [1:0] r;
	wire awready, wready, bvalid, arready, rvalid, start_in, pause_in, reset_in, trig_in;
	wire running, paused, done;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, gtab_time;
	wire [15:0] gtab_value, setpoint;
	wire [3:0] gtab_idx;
	wire [4:0] gtab_rows;
	int err_total = 0;
	int n_tests = 0;
	always #2 clk = ~clk;
	setpoint_programmer u_setpoint_programmer (.CLK(clk), .RESET_N(reset_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.START_IN(start_in), .PAUSE_IN(pause_in), .RESET_IN(reset_in), .TRIG_IN(trig_in),
		.GTAB_IDX(gtab_idx), .GTAB_TIME(gtab_time), .GTAB_VALUE(gtab_value),
		.GTAB_ROWS(gtab_rows), .SETPOINT(setpoint), .RUNNING(running), .PAUSED(paused),
		.DONE(done));
	cond_partner u_cond_partner (.CLK(clk), .GTAB_IDX(gtab_idx), .START_IN(start_in),
		.PAUSE_IN(pause_in), .RESET_IN(reset_in), .TRIG_IN(trig_in), .GTAB_TIME(gtab_time),
		.GTAB_VALUE(gtab_value), .GTAB_ROWS(gtab_rows));
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang(input logic ok);
		if (!ok) begin
			err_total++;
			test_done();
		end
	endtask
	// write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		hang(n < 64);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		hang(n < 64);
	endtask
	task automatic tk(input int n);
		repeat (n * TK) @(posedge clk);
	endtask
	// lines: 0 start, 1 pause, 2 reset, 3 trigger; two ticks let a sample land
	task automatic line(input int b, input logic v);
		cv[b] = v;
		@(posedge clk);
		u_cond_partner.drive(cv);
		tk(2);
	endtask
	task automatic t_regs;
		rd(8'h00);
		chk(d, 32'h00000010);
		rd(8'h04);
		chk(d, 32'h00000001);
		rd(8'h08);
		chk(d, 32'h000000FA);
		rd(8'h0C);
		chk(d, 32'h00000002);
		rd(8'h30);
		chk(r, 2'h2);
		wr(8'h30, 32'h00000001);
		chk(r, 2'h2);
		$display("test regs done");
	endtask
	task automatic t_local;
		int n;
		logic mid;
		wr(8'h08, 32'h00000020);
		wr(8'h40, 32'h00000000);
		wr(8'h44, 32'h00000100);
		wr(8'h48, 32'h00000004);
		wr(8'h4C, 32'h00000500);
		wr(8'h04, 32'h00000002);
		cv[0] = 1'b1;
		u_cond_partner.drive(cv);
		mid = 1'b0;
		for (n = 0; n < 40 * TK && done !== 1'b1; n++) begin
			@(posedge clk);
			if (setpoint > 16'h0100 && setpoint < 16'h0500) mid = 1'b1;
		end
		hang(n < 40 * TK);
		chk(mid, 1'b1);
		chk(n > 7 * TK && n < 12 * TK, 1'b1);
		tk(3);
		chk({done, running, setpoint}, {2'b10, 16'h0500});
		line(0, 1'b0);
		line(0, 1'b1);
		chk({done, running}, 2'b01);
		line(0, 1'b0);
		line(1, 1'b1);
		tk(10);
		chk({paused, running, done}, 3'b110);
		line(2, 1'b1);
		chk({paused, running, setpoint}, {2'b00, 16'h0100});
		line(1, 1'b0);
		line(0, 1'b1);
		chk(running, 1'b0);
		line(0, 1'b0);
		line(2, 1'b0);
		line(1, 1'b1);
		line(0, 1'b1);
		chk({paused, running}, 2'b10);
		line(1, 1'b0);
		line(0, 1'b0);
		$display("test local done");
	endtask
	task automatic t_global;
		wr(8'h04, 32'h00000001);
		wr(8'h00, 32'h00000051);
		line(0, 1'b1);
		line(0, 1'b0);
		chk({running, setpoint}, {1'b1, 16'h0020});
		line(1, 1'b1);
		line(1, 1'b0);
		chk(paused, 1'b1);
		line(0, 1'b1);
		line(0, 1'b0);
		line(3, 1'b1);
		line(3, 1'b0);
		chk({paused, running, setpoint}, {2'b11, 16'h0020});
		line(1, 1'b1);
		line(1, 1'b0);
		chk(paused, 1'b0);
		line(3, 1'b1);
		chk({done, setpoint}, {1'b1, 16'h0030});
		line(3, 1'b0);
		$display("test global done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_local();
		t_global();
		test_done();
	end
endmodule
bind setpoint_programmer setpoint_programmer_checker u_chk (.*);
